// ### flash_prefetch_predictor.sv
// Predictive prefetch, line fill, replacement and coherency logic of a flash prefetch cache
//
// Operation
// - After a line is placed, start a flash read of the next 16-byte line.
// - Prediction begins only after the first instruction fetch is seen.
// - Cacheable prediction delivers the next line into the prefetch buffer, or into the pseudo LRU line if it is fetched while the read runs.
// - Linear code finds the next line buffered before the previous is consumed.
// - A mismatching fetch redirects the predicted read, no extra latency.
// - Cache miss hitting the buffer copies data and tag into pseudo LRU line.
// - A line filled from the buffer becomes most recently used.
// - A full instruction-fetch miss reads flash and fills the pseudo LRU line.
// - Non-cacheable prediction serves accesses from the prefetch buffer only.
// - Non-cacheable prediction never touches cache lines or replacement state.
// - Linear non-cacheable code with prediction fetches with zero wait states.
// - Prefetched data is held at the flash output at most 3 cycles.
// - A data load that misses the cache aborts a predicted read and starts the load; no data prediction.
// - After an abort prediction stays idle until the next instruction fetch.
// - Next fetch after abort refills on miss or predicts on hit.
// - During flash programming the cache stays stalled.
// - Strict coherency: flash writes invalidate and unlock all lines.
// - Loose coherency: flash writes invalidate only unlocked lines.
// - No interrupt requests are raised.
// - A control register field selects predictive prefetching.
// - The data array loads only for cacheability attribute 3.
// - Each flash read lasts one cycle more than the programmed wait-state count.
// - A line is locked only when valid and lock are both 1.
`include "flash_prefetch_map.svh"
`default_nettype none
module flash_prefetch_predictor
	import flash_prefetch_pkg::*;
(
	input  wire logic         REF_CLK_I,
	input  wire logic         RST_N_I,
	input  wire logic         CPU_REQ_I,
	input  wire logic [31:0]  CPU_ADDR_I,
	input  wire logic         CPU_DATA_I,
	input  wire logic [2:0]   CPU_CCA_I,
	output logic              CPU_RVALID_O,
	output logic [31:0]       CPU_RDATA_O,
	output logic              CACHE_STALL_O,
	output logic              FLASH_RD_O,
	output logic [31:0]       FLASH_ADDR_O,
	input  wire logic [127:0] FLASH_RDATA_I,
	input  wire logic         FLASH_PROG_I,
	input  wire logic         AXI_AWVALID_I,
	output logic              AXI_AWREADY_O,
	input  wire logic [7:0]   AXI_AWADDR_I,
	input  wire logic         AXI_WVALID_I,
	output logic              AXI_WREADY_O,
	input  wire logic [31:0]  AXI_WDATA_I,
	input  wire logic [3:0]   AXI_WSTRB_I,
	output logic              AXI_BVALID_O,
	input  wire logic         AXI_BREADY_I,
	output logic [1:0]        AXI_BRESP_O,
	input  wire logic         AXI_ARVALID_I,
	output logic              AXI_ARREADY_O,
	input  wire logic [7:0]   AXI_ARADDR_I,
	output logic              AXI_RVALID_O,
	input  wire logic         AXI_RREADY_I,
	output logic [31:0]       AXI_RDATA_O,
	output logic [1:0]        AXI_RRESP_O
);

////////////////////////////////////////////////////////////////////////////////
// Reset release

logic   rst_meta;
logic   rst_n;
state_s r;
state_s n;

always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
	if (!RST_N_I) begin
		rst_meta <= 1'b0;
		rst_n    <= 1'b0;
	end else begin
		rst_meta <= 1'b1;
		rst_n    <= rst_meta;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Helpers

function automatic logic [2:0] plru_touch(input logic [2:0] t, input logic [1:0] i);
	logic [2:0] o;
	o = t;
	o[0] = ~i[1];
	if (i[1] == 1'b0) begin
		o[1] = ~i[0];
	end else begin
		o[2] = ~i[0];
	end
	return o;
endfunction

function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
	input logic [3:0] st);
	logic [31:0] o;
	o = old;
	for (int b = 0; b < 4; b++) begin
		if (st[b]) begin
			o[b*8 +: 8] = wd[b*8 +: 8];
		end
	end
	return o;
endfunction

logic [27:0] line;
logic [1:0]  wd;
logic        cach;
logic        req;
logic        chit;
logic [1:0]  hidx;
logic        bhit;
logic        fdone;
logic [1:0]  vic;
logic        vic_ok;
logic [3:0]  locked;
logic [1:0]  ridx;
logic [31:0] ctrl_rd;
logic [31:0] wmerged;

assign line   = CPU_ADDR_I[31:4];
assign wd     = CPU_ADDR_I[3:2];
assign cach   = (CPU_CCA_I == `CCA_CACHEABLE);
assign req    = CPU_REQ_I && !r.cpu_rvalid;
assign bhit   = r.bvld && (r.btag == line);
assign fdone  = (r.fst == F_READ) && (r.cnt == r.ws);
assign locked = r.lvld & r.llck;
assign ctrl_rd = {15'h0, r.coh, 10'h0, r.pfsel, 1'b0, r.ws};

always_comb begin
	chit = 1'b0;
	hidx = 2'h0;
	for (int i = 0; i < `NUM_LINES; i++) begin
		if (r.lvld[i] && (r.ltag[i] == line)) begin
			chit = 1'b1;
			hidx = 2'(i);
		end
	end
end

// Victim is the pseudo LRU line unless locked; then the highest-numbered unlocked line
always_comb begin
	vic    = r.plru[0] ? {1'b1, r.plru[2]} : {1'b0, r.plru[1]};
	vic_ok = !locked[vic];
	for (int i = `NUM_LINES - 1; i >= 0; i--) begin
		if (!vic_ok && !locked[i]) begin
			vic    = 2'(i);
			vic_ok = 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Next state

always_comb begin
	n = r;
	n.cpu_rvalid = 1'b0;
	n.stall      = FLASH_PROG_I;
	ridx         = AXI_ARADDR_I[3:2];
	wmerged      = strb_merge(ctrl_rd, r.w_data, r.w_strb);

	// Wait-state and output-hold counters
	if (r.fst == F_READ && !fdone) begin
		n.cnt = r.cnt + 3'h1;
	end
	if (r.fst == F_HOLD) begin
		if (r.hcnt == `HOLD_CYCLES - 2'h1) begin
			n.fst = F_IDLE;
		end else begin
			n.hcnt = r.hcnt + 2'h1;
		end
	end

	if (FLASH_PROG_I) begin
		// Nothing is served and any flash read is dropped
		n.fst     = F_IDLE;
		n.bvld    = 1'b0;
		n.pred_on = 1'b0;
	end else if (fdone) begin
		n.fst = F_IDLE;
		if (r.fdem) begin
			n.cpu_rdata  = FLASH_RDATA_I[r.fword*32 +: 32];
			n.cpu_rvalid = 1'b1;
			if (!r.fdat && r.fcach && vic_ok) begin
				n.ldata[vic] = FLASH_RDATA_I;
				n.ltag[vic]  = r.faddr;
				n.lvld[vic]  = 1'b1;
				n.plru       = plru_touch(r.plru, vic);
			end else if (!r.fdat && !r.fcach) begin
				n.bdata = FLASH_RDATA_I;
				n.btag  = r.faddr;
				n.bvld  = 1'b1;
			end
			// Non-cacheable prediction waits for the last word: the buffer still serves the running line
			if (!r.fdat && (r.fcach ? r.pfsel[0] : (r.pfsel[1] && r.fword == 2'h3))) begin
				n.pred_on = 1'b1;
				n.fst     = F_READ;
				n.cnt     = 3'h0;
				n.faddr   = r.faddr + 28'h1;
				n.fdem    = 1'b0;
				n.fdat    = 1'b0;
				n.fcach   = r.fcach;
			end
		end else begin
			n.bdata = FLASH_RDATA_I;
			n.btag  = r.faddr;
			n.bvld  = 1'b1;
			n.fst   = F_HOLD;
			n.hcnt  = 2'h0;
		end
	end else if (req) begin
		if (chit && cach) begin
			n.cpu_rdata  = r.ldata[hidx][wd*32 +: 32];
			n.cpu_rvalid = 1'b1;
			n.plru       = plru_touch(r.plru, hidx);
			if (!CPU_DATA_I && r.pfsel[0] && r.fst != F_READ &&
				!(r.bvld && r.btag == line + 28'h1)) begin
				n.pred_on = 1'b1;
				n.fst     = F_READ;
				n.cnt     = 3'h0;
				n.faddr   = line + 28'h1;
				n.fdem    = 1'b0;
				n.fdat    = 1'b0;
				n.fcach   = 1'b1;
			end
		end else if (!CPU_DATA_I && bhit) begin
			n.cpu_rdata  = r.bdata[wd*32 +: 32];
			n.cpu_rvalid = 1'b1;
			if (cach && vic_ok) begin
				n.ldata[vic] = r.bdata;
				n.ltag[vic]  = r.btag;
				n.lvld[vic]  = 1'b1;
				n.plru       = plru_touch(r.plru, vic);
				n.bvld       = 1'b0;
			end
			if ((cach ? r.pfsel[0] : (r.pfsel[1] && wd == 2'h3)) && r.fst != F_READ) begin
				n.pred_on = 1'b1;
				n.fst     = F_READ;
				n.cnt     = 3'h0;
				n.faddr   = line + 28'h1;
				n.fdem    = 1'b0;
				n.fdat    = 1'b0;
				n.fcach   = cach;
			end
		end else if (r.fst == F_READ && !r.fdem && !CPU_DATA_I && r.faddr == line) begin
			// Predicted read already targets this line
			n.fdem  = 1'b1;
			n.fcach = cach;
			n.fword = wd;
		end else if (!(r.fst == F_READ && r.fdem)) begin
			if (r.fst == F_READ) begin
				n.bvld = 1'b0;
			end
			if (CPU_DATA_I) begin
				n.pred_on = 1'b0;
			end else begin
				n.pred_on = r.pred_on || (cach ? r.pfsel[0] : r.pfsel[1]);
			end
			n.fst   = F_READ;
			n.cnt   = 3'h0;
			n.faddr = line;
			n.fdem  = 1'b1;
			n.fdat  = CPU_DATA_I;
			n.fcach = cach;
			n.fword = wd;
		end
	end

	// Register bus, read side
	if (r.rvalid && AXI_RREADY_I) begin
		n.rvalid = 1'b0;
	end
	if (AXI_ARVALID_I && r.arready) begin
		n.rvalid = 1'b1;
		n.rresp  = `RESP_OKAY;
		n.rdata  = 32'h0;
		if (AXI_ARADDR_I[7:2] == `OFS_CTRL >> 2) begin
			n.rdata = ctrl_rd;
		end else if (AXI_ARADDR_I[7:2] == `OFS_STATUS >> 2) begin
			n.rdata = {20'h0, r.llck, r.lvld, r.stall, (r.fst == F_READ), r.pred_on, r.bvld};
		end else if (AXI_ARADDR_I[7:4] == `OFS_LTAG_BASE >> 4) begin
			n.rdata = {r.ltag[ridx], 1'b0, r.lvld[ridx], r.llck[ridx], 1'b0};
		end else begin
			n.rresp = `RESP_SLVERR;
		end
	end
	n.arready = !n.rvalid;

	// Register bus, write side
	if (r.bvalid && AXI_BREADY_I) begin
		n.bvalid = 1'b0;
	end
	if (AXI_AWVALID_I && r.awready) begin
		n.aw_have = 1'b1;
		n.aw_addr = AXI_AWADDR_I;
	end
	if (AXI_WVALID_I && r.wready) begin
		n.w_have = 1'b1;
		n.w_data = AXI_WDATA_I;
		n.w_strb = AXI_WSTRB_I;
	end
	if (r.aw_have && r.w_have && !r.bvalid) begin
		n.aw_have = 1'b0;
		n.w_have  = 1'b0;
		n.bvalid  = 1'b1;
		n.bresp   = `RESP_OKAY;
		if (r.aw_addr[7:2] == `OFS_CTRL >> 2) begin
			n.ws    = wmerged[`CTRL_WS_MSB:`CTRL_WS_LSB];
			n.pfsel = wmerged[`CTRL_PF_MSB:`CTRL_PF_LSB];
			n.coh   = wmerged[`CTRL_COH_BIT];
		end else if (r.aw_addr[7:2] == `OFS_STATUS >> 2) begin
			n.bresp = `RESP_OKAY;
		end else if (r.aw_addr[7:4] == `OFS_LTAG_BASE >> 4) begin
			if (r.w_strb[0]) begin
				n.llck[r.aw_addr[3:2]] = r.w_data[`LTAG_LOCK_BIT];
			end
		end else begin
			n.bresp = `RESP_SLVERR;
		end
	end
	n.awready = !n.aw_have && !n.bvalid;
	n.wready  = !n.w_have && !n.bvalid;

	// Coherency while flash is written or programmed
	if (FLASH_PROG_I) begin
		if (r.coh) begin
			n.lvld = 4'h0;
			n.llck = 4'h0;
		end else begin
			n.lvld = r.lvld & r.llck;
		end
	end
	n.frd = (n.fst != F_IDLE);
end

////////////////////////////////////////////////////////////////////////////////
// State register and outputs

always_ff @(posedge REF_CLK_I or negedge rst_n) begin
	if (!rst_n) begin
		r       <= '0;
		r.ws    <= `RST_WS;
		r.pfsel <= `RST_PF;
		r.coh   <= `RST_COH;
	end else begin
		r <= n;
	end
end

assign CPU_RVALID_O  = r.cpu_rvalid;
assign CPU_RDATA_O   = r.cpu_rdata;
assign CACHE_STALL_O = r.stall;
assign FLASH_RD_O    = r.frd;
assign FLASH_ADDR_O  = {r.faddr, 4'h0};
assign AXI_AWREADY_O = r.awready;
assign AXI_WREADY_O  = r.wready;
assign AXI_BVALID_O  = r.bvalid;
assign AXI_BRESP_O   = r.bresp;
assign AXI_ARREADY_O = r.arready;
assign AXI_RVALID_O  = r.rvalid;
assign AXI_RDATA_O   = r.rdata;
assign AXI_RRESP_O   = r.rresp;

endmodule
`default_nettype wire

// ### flash_prefetch_map.svh
// Register offsets, field positions, reset values and timing counts of the prefetch predictor
`ifndef FLASH_PREFETCH_MAP_SVH
`define FLASH_PREFETCH_MAP_SVH
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_LTAG_BASE   8'h10
`define CTRL_WS_LSB     0
`define CTRL_WS_MSB     2
`define CTRL_PF_LSB     4
`define CTRL_PF_MSB     5
`define CTRL_COH_BIT    16
`define LTAG_LOCK_BIT   1
`define LTAG_VALID_BIT  2
`define RST_WS          3'h7
`define RST_PF          2'h0
`define RST_COH         1'h0
`define CCA_CACHEABLE   3'h3
`define HOLD_CYCLES     2'h3
`define NUM_LINES       4
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// ### flash_prefetch_pkg.sv
// Types of the flash prefetch predictor
`default_nettype none
package flash_prefetch_pkg;
	typedef enum logic [1:0] {
		F_IDLE = 2'b00,
		F_READ = 2'b01,
		F_HOLD = 2'b10
	} fstate_e;
	typedef struct packed {
		fstate_e           fst;
		logic              frd;
		logic [2:0]        cnt;
		logic [1:0]        hcnt;
		logic [27:0]       faddr;
		logic              fdem;
		logic              fdat;
		logic              fcach;
		logic [1:0]        fword;
		logic [127:0]      bdata;
		logic [27:0]       btag;
		logic              bvld;
		logic              pred_on;
		logic [3:0][127:0] ldata;
		logic [3:0][27:0]  ltag;
		logic [3:0]        lvld;
		logic [3:0]        llck;
		logic [2:0]        plru;
		logic [2:0]        ws;
		logic [1:0]        pfsel;
		logic              coh;
		logic              cpu_rvalid;
		logic [31:0]       cpu_rdata;
		logic              stall;
		logic              aw_have;
		logic [7:0]        aw_addr;
		logic              w_have;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} state_s;
endpackage
`default_nettype wire

// ### flash_array_model.sv
// Program flash array model answering line reads
`default_nettype none
module flash_array_model (
	input  wire logic         clk_i,
	input  wire logic         rd_i,
	input  wire logic [31:0]  addr_i,
	output logic      [127:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [127:0] junk = {4{32'hC3C3_3C3C}};
	// Outside a read the lines show a pattern that flips every cycle
	always_ff @(posedge clk_i) begin
		junk <= ~junk;
	end
	always_comb begin
		rdata_o = junk;
		if (rd_i) begin
			for (int k = 0; k < 4; k++) begin
				rdata_o[32*k +: 32] = {addr_i[31:4], 2'(k), 2'b00} ^ 32'h5A5A_0000;
			end
		end
	end
endmodule
`default_nettype wire

// ### flash_prefetch_predictor_asserts.sv
// Port checker of the flash prefetch predictor
`default_nettype none
module flash_prefetch_predictor_asserts (
	input wire logic        REF_CLK_I,
	input wire logic        RST_N_I,
	input wire logic        CPU_REQ_I,
	input wire logic [31:0] CPU_ADDR_I,
	input wire logic        CPU_DATA_I,
	input wire logic        CPU_RVALID_O,
	input wire logic        CACHE_STALL_O,
	input wire logic        FLASH_RD_O,
	input wire logic [31:0] FLASH_ADDR_O,
	input wire logic        FLASH_PROG_I
);
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RST_N_I);
	logic [3:0]  run_len;
	logic [31:0] last_addr;
	// Cycles one flash address has been driven without a break
	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			run_len   <= 4'h0;
			last_addr <= 32'h0;
		end else begin
			run_len   <= (FLASH_RD_O && !CACHE_STALL_O && FLASH_ADDR_O == last_addr && run_len != 4'hF) ? run_len + 4'h1 : 4'h0;
			last_addr <= FLASH_ADDR_O;
		end
	end
	property p_stall_on;
		FLASH_PROG_I |=> CACHE_STALL_O;
	endproperty
	a_stall_on: assert property (p_stall_on) else $error("cache not stalled during programming");
	property p_no_answer;
		FLASH_PROG_I |=> !CPU_RVALID_O;
	endproperty
	a_no_answer: assert property (p_no_answer) else $error("answer given during programming");
	property p_aligned;
		FLASH_RD_O |-> FLASH_ADDR_O[3:0] == 4'h0;
	endproperty
	a_aligned: assert property (p_aligned) else $error("flash address not line aligned");
	property p_data_quiet;
		CPU_RVALID_O && CPU_DATA_I |-> !FLASH_RD_O;
	endproperty
	a_data_quiet: assert property (p_data_quiet) else $error("flash read after a data load");
	property p_stay_idle;
		CPU_RVALID_O && CPU_DATA_I ##1 (!CPU_REQ_I) [*2] |-> !FLASH_RD_O;
	endproperty
	a_stay_idle: assert property (p_stay_idle) else $error("prediction restarted without a fetch");
	property p_data_flash;
		$rose(CPU_REQ_I) && CPU_DATA_I && !FLASH_PROG_I |-> ##[1:2] (FLASH_RD_O && FLASH_ADDR_O[31:4] == CPU_ADDR_I[31:4]);
	endproperty
	a_data_flash: assert property (p_data_flash) else $error("data load not sent to flash");
	property p_redirect;
		$rose(CPU_REQ_I) && !CPU_DATA_I && !FLASH_PROG_I && FLASH_RD_O && CPU_ADDR_I[31:4] != FLASH_ADDR_O[31:4]
			|-> ##[1:2] (CPU_RVALID_O || FLASH_ADDR_O[31:4] == CPU_ADDR_I[31:4]);
	endproperty
	a_redirect: assert property (p_redirect) else $error("predicted read not redirected");
	property p_hold_max;
		run_len <= 4'hA;
	endproperty
	a_hold_max: assert property (p_hold_max) else $error("flash output held too long");
endmodule
bind flash_prefetch_predictor flash_prefetch_predictor_asserts i_chk (.REF_CLK_I, .RST_N_I, .CPU_REQ_I, .CPU_ADDR_I,
	.CPU_DATA_I, .CPU_RVALID_O, .CACHE_STALL_O, .FLASH_RD_O, .FLASH_ADDR_O, .FLASH_PROG_I);
`default_nettype wire

// ### tb.sv
// Self-checking bench of the flash prefetch predictor
`include "flash_prefetch_map.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic         REF_CLK_I = 0, RST_N_I = 0, CPU_REQ_I = 0, CPU_DATA_I = 0, FLASH_PROG_I = 0;
	logic [31:0]  CPU_ADDR_I = 0, AXI_WDATA_I = 0;
	logic [2:0]   CPU_CCA_I = 0;
	logic         AXI_AWVALID_I = 0, AXI_WVALID_I = 0, AXI_BREADY_I = 0, AXI_ARVALID_I = 0, AXI_RREADY_I = 0;
	logic [7:0]   AXI_AWADDR_I = 0, AXI_ARADDR_I = 0;
	logic [3:0]   AXI_WSTRB_I = 4'hF;
	logic         CPU_RVALID_O, CACHE_STALL_O, FLASH_RD_O, AXI_AWREADY_O, AXI_WREADY_O, AXI_BVALID_O;
	logic         AXI_ARREADY_O, AXI_RVALID_O;
	logic [31:0]  CPU_RDATA_O, FLASH_ADDR_O, AXI_RDATA_O;
	logic [1:0]   AXI_BRESP_O, AXI_RRESP_O;
	logic [127:0] FLASH_RDATA_I;
	int           bad_count = 0, n_checks = 0;
	logic [31:0]  cq[$];
	logic [33:0]  rq[$], rm[$];
	logic [1:0]   bq[$];
	flash_prefetch_predictor i_dut (.REF_CLK_I, .RST_N_I, .CPU_REQ_I, .CPU_ADDR_I, .CPU_DATA_I, .CPU_CCA_I,
		.CPU_RVALID_O, .CPU_RDATA_O, .CACHE_STALL_O, .FLASH_RD_O, .FLASH_ADDR_O, .FLASH_RDATA_I, .FLASH_PROG_I,
		.AXI_AWVALID_I, .AXI_AWREADY_O, .AXI_AWADDR_I, .AXI_WVALID_I, .AXI_WREADY_O, .AXI_WDATA_I, .AXI_WSTRB_I,
		.AXI_BVALID_O, .AXI_BREADY_I, .AXI_BRESP_O, .AXI_ARVALID_I, .AXI_ARREADY_O, .AXI_ARADDR_I, .AXI_RVALID_O,
		.AXI_RREADY_I, .AXI_RDATA_O, .AXI_RRESP_O);
	flash_array_model i_flash (.clk_i(REF_CLK_I), .rd_i(FLASH_RD_O), .addr_i(FLASH_ADDR_O), .rdata_o(FLASH_RDATA_I));
	initial begin
		forever #50 REF_CLK_I = ~REF_CLK_I;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] fw(input logic [31:0] a);
		return {a[31:2], 2'b00} ^ 32'h5A5A_0000;
	endfunction
	task check(input logic [33:0] seen, input logic [33:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic at, wt;
		at = 0;
		wt = 0;
		bq.push_back(`RESP_OKAY);
		@(posedge REF_CLK_I);
		AXI_AWADDR_I <= a;
		AXI_WDATA_I <= d;
		AXI_AWVALID_I <= 1'b1;
		AXI_WVALID_I <= 1'b1;
		AXI_BREADY_I <= 1'b1;
		do begin
			@(negedge REF_CLK_I);
			at = at | AXI_AWREADY_O;
			wt = wt | AXI_WREADY_O;
			@(posedge REF_CLK_I);
			if (at) AXI_AWVALID_I <= 1'b0;
			if (wt) AXI_WVALID_I <= 1'b0;
		end while (!(at && wt));
		do @(negedge REF_CLK_I); while (AXI_BVALID_O !== 1'b1);
		@(posedge REF_CLK_I);
		AXI_BREADY_I <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [33:0] exp, input logic [33:0] msk);
		rq.push_back(exp);
		rm.push_back(msk);
		@(posedge REF_CLK_I);
		AXI_ARADDR_I <= a;
		AXI_ARVALID_I <= 1'b1;
		AXI_RREADY_I <= 1'b1;
		do @(negedge REF_CLK_I); while (AXI_ARREADY_O !== 1'b1);
		@(posedge REF_CLK_I);
		AXI_ARVALID_I <= 1'b0;
		do @(negedge REF_CLK_I); while (AXI_RVALID_O !== 1'b1);
		@(posedge REF_CLK_I);
		AXI_RREADY_I <= 1'b0;
	endtask
	task fetch(input logic [31:0] a, input logic d, input logic [2:0] cca, output int lat, output logic [31:0] fa);
		cq.push_back(fw(a));
		@(posedge REF_CLK_I);
		CPU_REQ_I <= 1'b1;
		CPU_ADDR_I <= a;
		CPU_DATA_I <= d;
		CPU_CCA_I <= cca;
		lat = 0;
		do begin
			@(negedge REF_CLK_I);
			lat++;
		end while (CPU_RVALID_O !== 1'b1);
		fa = FLASH_ADDR_O;
		@(posedge REF_CLK_I);
		CPU_REQ_I <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(negedge REF_CLK_I) begin
		if (CPU_RVALID_O === 1'b1) check({2'b00, CPU_RDATA_O}, {2'b00, cq.pop_front()});
		if (AXI_RVALID_O === 1'b1 && AXI_RREADY_I) check({AXI_RRESP_O, AXI_RDATA_O} & rm.pop_front(), rq.pop_front());
		if (AXI_BVALID_O === 1'b1 && AXI_BREADY_I) check({32'h0, AXI_BRESP_O}, {32'h0, bq.pop_front()});
	end
	initial begin
		repeat (3000) @(posedge REF_CLK_I);
		bad_count++;
		report_and_stop;
	end
	initial begin
		int lat;
		logic [31:0] fa, a, b, c, d, e;
		void'($urandom(32'h2706));
		a = $urandom & 32'h000F_FF00;
		b = a ^ 32'h0010_0000;
		c = a ^ 32'h0020_0044;
		d = a ^ 32'h0040_0000;
		e = b ^ 32'h0000_0400;
		repeat (6) @(posedge REF_CLK_I);
		RST_N_I <= 1'b1;
		repeat (3) @(posedge REF_CLK_I);
		rd(`OFS_CTRL, 34'h7, {34{1'b1}});
		rd(8'h40, {`RESP_SLVERR, 32'h0}, {34{1'b1}});
		wr(`OFS_CTRL, 32'h31);
		repeat (4) @(posedge REF_CLK_I);
		@(negedge REF_CLK_I);
		check({33'h0, FLASH_RD_O}, 34'h0);
		for (int i = 0; i < 16; i++) begin
			fetch(a + 32'(4 * i), 1'b0, 3'h3, lat, fa);
			check(34'(lat), (i == 0) ? 34'h4 : 34'h2);
			if (i == 0) check({2'b00, fa}, {2'b00, a + 32'h10});
		end
		for (int i = 1; i < 4; i++) wr(`OFS_LTAG_BASE + 8'(4 * i), 32'h2);
		rd(`OFS_STATUS, 34'hEF0, 34'hFF0);
		@(posedge REF_CLK_I);
		FLASH_PROG_I <= 1'b1;
		repeat (3) @(posedge REF_CLK_I);
		FLASH_PROG_I <= 1'b0;
		rd(`OFS_STATUS, 34'hEE0, 34'hFF0);
		wr(`OFS_CTRL, 32'h0001_0031);
		// Fetch issued from non-cacheable space while programming
		fork
			fetch(d, 1'b0, 3'h2, lat, fa);
			begin
				@(posedge REF_CLK_I);
				FLASH_PROG_I <= 1'b1;
				repeat (4) @(posedge REF_CLK_I);
				FLASH_PROG_I <= 1'b0;
			end
		join
		for (int i = 1; i < 8; i++) begin
			fetch(d + 32'(4 * i), 1'b0, 3'h2, lat, fa);
			check(34'(lat), 34'h2);
		end
		rd(`OFS_STATUS, 34'h0, 34'hFF0);
		// Long flash reads so that the next fetches land inside a predicted read
		wr(`OFS_CTRL, 32'h0001_0037);
		fetch(b, 1'b0, 3'h3, lat, fa);
		check(34'(lat), 34'hA);
		fetch(e, 1'b0, 3'h3, lat, fa);
		check(34'(lat), 34'hA);
		fetch(c, 1'b1, 3'h3, lat, fa);
		check(34'(lat), 34'hA);
		repeat (3) @(posedge REF_CLK_I);
		@(negedge REF_CLK_I);
		check({33'h0, FLASH_RD_O}, 34'h0);
		fetch(e + 32'h10, 1'b0, 3'h3, lat, fa);
		check(34'(lat), 34'hA);
		check({2'b00, fa}, {2'b00, e + 32'h20});
		repeat (4) @(posedge REF_CLK_I);
		report_and_stop;
	end
endmodule
`default_nettype wire
